// >>> hw/asc_pkg.sv
package asc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_REFCFG = 8'h04;
  localparam logic [7:0] OFS_FMTCFG = 8'h08;
  localparam logic [7:0] OFS_RESHI  = 8'h0c;
  localparam logic [7:0] OFS_RESLO  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CTRL_ON_BIT   = 0;
  localparam int CTRL_GO_BIT   = 1;
  localparam int CTRL_CHAN_LSB = 2;
  localparam int REF_NREF_BIT  = 5;
  localparam int REF_PREF_BIT  = 4;
  localparam int REF_PCFG_LSB  = 0;
  localparam int FMT_JUST_BIT  = 7;
  localparam int FMT_ACQ_LSB   = 3;
  localparam int FMT_CLK_LSB   = 0;
  localparam int STAT_DONE_BIT = 0;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] REFCFG_RST = 8'h00;
  localparam logic [7:0] FMTCFG_RST = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int TCY_NS        = 80;
  localparam int TCY_CYC_INT   = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] TCY_CYC   = 3'(TCY_CYC_INT);
  localparam logic [4:0] CONV_LAST = 5'h0a;
  localparam logic [4:0] WAIT_LAST = 5'h01;
  localparam logic [9:0] SAR_MSB   = 10'h200;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DLY  = 3'b001,
    ST_ACQ  = 3'b010,
    ST_CONV = 3'b011,
    ST_WAIT = 3'b100
  } asc_state_t;

  // ************************************************************
  // Decoders
  // ************************************************************
  function automatic logic [15:0] pin_mask(input logic [3:0] code);
    logic [15:0] m;
    m = 16'hffff;
    for (int i = 0; i < 16; i++) begin
      if (code != 4'h0 && i >= 15 - int'(code)) begin
        m[i] = 1'b0;
      end
    end
    return m;
  endfunction

  function automatic logic [5:0] div_last(input logic [2:0] sel);
    unique case (sel)
      3'b000: return 6'h01;
      3'b001: return 6'h07;
      3'b010: return 6'h1f;
      3'b100: return 6'h03;
      3'b101: return 6'h0f;
      3'b110: return 6'h3f;
      default: return 6'h00;
    endcase
  endfunction

  function automatic logic [4:0] acq_ticks(input logic [2:0] sel);
    unique case (sel)
      3'b000: return 5'h00;
      3'b001: return 5'h02;
      3'b010: return 5'h04;
      3'b011: return 5'h06;
      3'b100: return 5'h08;
      3'b101: return 5'h0c;
      3'b110: return 5'h10;
      3'b111: return 5'h14;
    endcase
  endfunction

  function automatic logic [15:0] fmt_result(input logic [9:0] code,
                                             input logic       right);
    return right ? {6'h00, code} : {code, 6'h00};
  endfunction

endpackage

// >>> hw/asc_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Negative reference bit set picks channel 2 pin, clear picks ground.
// - Positive reference bit set picks channel 3 pin, clear picks supply.
// - Pin code zero all analog; k>0 makes channels 15-k upward digital.
// - Justify bit set right-aligns result, clear left-aligns it.
// - Acquisition field gives 0,2,4,6,8,12,16,20 bit periods.
// - Clock field picks divide 2,8,32,4,16,64 or internal RC.
// - RC clock waits one instruction cycle before conversion clock starts.
// - Only the RC clock keeps converting during sleep.
// - On completion load result, clear go flag, set done flag.
// - Reset returns all registers but the result bytes, turns converter off, aborts conversion.
// - Power-on reset leaves the result bytes undefined.
// - Programmed acquisition samples that long after go, then converts.
// - Two bit periods must pass after a conversion before acquiring.
// - Result comes by successive approximation of the held sample.
// - Hold capacitor disconnects from the pin when conversion begins.
// - Go flag reads one while converting, zero idle; setting starts.
// - A conversion takes eleven bit periods.
// - Clearing go mid-conversion aborts, result keeps its old value.
// - Converter on bit enables the converter when set.
module asc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rc_tick,
  input  wire logic        sleep_mode,
  input  wire logic        cmp_high,
  output logic      [9:0]  dac_code,
  output logic             sample_connect,
  output logic             neg_ref_select,
  output logic             pos_ref_select,
  output logic      [15:0] analog_pin_mask,
  output logic      [3:0]  channel_select,
  output logic             conv_done_flag
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic              converter_on_q;
  logic              go_q;
  logic [3:0]        chan_q;
  logic              nref_q;
  logic              pref_q;
  logic [3:0]        pin_config_code_q;
  logic              result_justify_q;
  logic [2:0]        acq_time_select_q;
  logic [2:0]        conv_clock_select_q;
  logic [7:0]        result_high_byte_q;
  logic [7:0]        result_low_byte_q;
  logic              flag_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       prdata_q;
  asc_pkg::asc_state_t state_q;
  logic [5:0]        div_cnt_q;
  logic [4:0]        step_q;
  logic [2:0]        dly_q;
  logic [9:0]        sar_q;
  logic [15:0]       mask_q;
  logic              sample_q;

  logic              access;
  logic              wr_en;
  logic              mapped;
  logic              is_rc;
  logic              div_hit;
  logic              tick;
  logic              done_ev;
  logic              abort_ev;
  logic [3:0]        bit_idx;
  logic [9:0]        final_code;
  logic [15:0]       fmt;
  logic [31:0]       rd_mux;

  // ************************************************************
  // APB slave, one wait state per access
  // ************************************************************
  assign access = psel & penable & pready_q;
  assign wr_en  = access & pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      asc_pkg::OFS_CTRL:   rd_mux = {26'h0, chan_q, go_q, converter_on_q};
      asc_pkg::OFS_REFCFG: rd_mux = {26'h0, nref_q, pref_q, pin_config_code_q};
      asc_pkg::OFS_FMTCFG: rd_mux = {24'h0, result_justify_q, 1'b0,
                                     acq_time_select_q, conv_clock_select_q};
      asc_pkg::OFS_RESHI:  rd_mux = {24'h0, result_high_byte_q};
      asc_pkg::OFS_RESLO:  rd_mux = {24'h0, result_low_byte_q};
      asc_pkg::OFS_STATUS: rd_mux = {31'h0, flag_q};
      default:             mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      if (psel & penable & ~pready_q & ~pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on_q      <= asc_pkg::CTRL_RST[asc_pkg::CTRL_ON_BIT];
      chan_q              <= asc_pkg::CTRL_RST[5:2];
      nref_q              <= asc_pkg::REFCFG_RST[asc_pkg::REF_NREF_BIT];
      pref_q              <= asc_pkg::REFCFG_RST[asc_pkg::REF_PREF_BIT];
      pin_config_code_q   <= asc_pkg::REFCFG_RST[3:0];
      result_justify_q    <= asc_pkg::FMTCFG_RST[asc_pkg::FMT_JUST_BIT];
      acq_time_select_q   <= asc_pkg::FMTCFG_RST[5:3];
      conv_clock_select_q <= asc_pkg::FMTCFG_RST[2:0];
    end else if (wr_en) begin
      if (paddr == asc_pkg::OFS_CTRL) begin
        converter_on_q <= pwdata[asc_pkg::CTRL_ON_BIT];
        chan_q <= pwdata[asc_pkg::CTRL_CHAN_LSB +: 4];
      end
      if (paddr == asc_pkg::OFS_REFCFG) begin
        nref_q            <= pwdata[asc_pkg::REF_NREF_BIT];
        pref_q            <= pwdata[asc_pkg::REF_PREF_BIT];
        pin_config_code_q <= pwdata[asc_pkg::REF_PCFG_LSB +: 4];
      end
      if (paddr == asc_pkg::OFS_FMTCFG) begin
        result_justify_q    <= pwdata[asc_pkg::FMT_JUST_BIT];
        acq_time_select_q   <= pwdata[asc_pkg::FMT_ACQ_LSB +: 3];
        conv_clock_select_q <= pwdata[asc_pkg::FMT_CLK_LSB +: 3];
      end
    end
  end

  // ************************************************************
  // Conversion clock
  // ************************************************************
  assign is_rc   = conv_clock_select_q[1:0] == 2'b11;
  assign div_hit = div_cnt_q == asc_pkg::div_last(conv_clock_select_q);
  // Divider clocks stop in sleep; only the RC source survives there
  assign tick = (is_rc ? rc_tick : div_hit)
              & (is_rc | ~sleep_mode)
              & (state_q == asc_pkg::ST_ACQ || state_q == asc_pkg::ST_CONV
                 || state_q == asc_pkg::ST_WAIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 6'h00;
    end else if (state_q == asc_pkg::ST_IDLE || state_q == asc_pkg::ST_DLY
                 || div_hit || is_rc || sleep_mode) begin
      div_cnt_q <= 6'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  assign bit_idx    = 4'(5'd10 - step_q);
  assign final_code = {sar_q[9:1], cmp_high};
  assign done_ev    = state_q == asc_pkg::ST_CONV && tick
                    && step_q == asc_pkg::CONV_LAST && go_q && converter_on_q;
  assign abort_ev   = ~go_q && (state_q == asc_pkg::ST_DLY
                    || state_q == asc_pkg::ST_ACQ
                    || state_q == asc_pkg::ST_CONV);
  assign fmt        = asc_pkg::fmt_result(final_code, result_justify_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= asc_pkg::ST_IDLE;
      step_q  <= 5'h00;
      dly_q   <= 3'h0;
      sar_q   <= 10'h000;
    end else if (!converter_on_q) begin
      state_q <= asc_pkg::ST_IDLE;
      step_q  <= 5'h00;
    end else if (abort_ev) begin
      state_q <= asc_pkg::ST_WAIT;
      step_q  <= 5'h00;
    end else begin
      unique case (state_q)
        asc_pkg::ST_IDLE: begin
          step_q <= 5'h00;
          dly_q  <= 3'h0;
          if (go_q) begin
            if (is_rc) begin
              state_q <= asc_pkg::ST_DLY;
            end else if (acq_time_select_q != 3'b000) begin
              state_q <= asc_pkg::ST_ACQ;
            end else begin
              state_q <= asc_pkg::ST_CONV;
              sar_q   <= asc_pkg::SAR_MSB;
            end
          end
        end
        asc_pkg::ST_DLY: begin
          dly_q <= dly_q + 3'h1;
          if (dly_q == asc_pkg::TCY_CYC - 3'h1) begin
            if (acq_time_select_q != 3'b000) begin
              state_q <= asc_pkg::ST_ACQ;
            end else begin
              state_q <= asc_pkg::ST_CONV;
              sar_q   <= asc_pkg::SAR_MSB;
            end
          end
        end
        asc_pkg::ST_ACQ: begin
          if (tick) begin
            step_q <= step_q + 5'h01;
            if (step_q + 5'h01 >= asc_pkg::acq_ticks(acq_time_select_q)) begin
              state_q <= asc_pkg::ST_CONV;
              step_q  <= 5'h00;
              sar_q   <= asc_pkg::SAR_MSB;
            end
          end
        end
        asc_pkg::ST_CONV: begin
          if (tick) begin
            step_q <= step_q + 5'h01;
            if (step_q != 5'h00) begin
              sar_q[bit_idx] <= cmp_high;
              if (bit_idx != 4'h0) begin
                sar_q[bit_idx - 4'h1] <= 1'b1;
              end
            end
            if (step_q == asc_pkg::CONV_LAST) begin
              state_q <= asc_pkg::ST_WAIT;
              step_q  <= 5'h00;
            end
          end
        end
        asc_pkg::ST_WAIT: begin
          if (tick) begin
            step_q <= step_q + 5'h01;
            if (step_q == asc_pkg::WAIT_LAST) begin
              state_q <= asc_pkg::ST_IDLE;
            end
          end
        end
        default: state_q <= asc_pkg::ST_IDLE;
      endcase
    end
  end

  // Go flag: completion clear beats a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q <= asc_pkg::CTRL_RST[asc_pkg::CTRL_GO_BIT];
    end else if (done_ev || !converter_on_q) begin
      go_q <= 1'b0;
    end else if (wr_en && paddr == asc_pkg::OFS_CTRL) begin
      // Needs the converter already on; same write cannot start it
      go_q <= pwdata[asc_pkg::CTRL_GO_BIT];
    end
  end

  // Hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (done_ev) begin
      flag_q <= 1'b1;
    end else if (wr_en && paddr == asc_pkg::OFS_STATUS) begin
      flag_q <= pwdata[asc_pkg::STAT_DONE_BIT];
    end
  end

  // No reset: contents after power-up are whatever the cells hold
  always_ff @(posedge pclk) begin
    if (done_ev) begin
      result_high_byte_q <= fmt[15:8];
      result_low_byte_q  <= fmt[7:0];
    end else if (wr_en) begin
      if (paddr == asc_pkg::OFS_RESHI) begin
        result_high_byte_q <= pwdata[7:0];
      end
      if (paddr == asc_pkg::OFS_RESLO) begin
        result_low_byte_q <= pwdata[7:0];
      end
    end
  end

  // ************************************************************
  // Analog side
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q   <= 16'hffff;
      sample_q <= 1'b0;
    end else begin
      mask_q   <= asc_pkg::pin_mask(pin_config_code_q);
      sample_q <= converter_on_q && (state_q == asc_pkg::ST_IDLE
                  || state_q == asc_pkg::ST_DLY
                  || state_q == asc_pkg::ST_ACQ);
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign dac_code        = sar_q;
  assign sample_connect  = sample_q;
  assign neg_ref_select  = nref_q;
  assign pos_ref_select  = pref_q;
  assign analog_pin_mask = mask_q;
  assign channel_select  = chan_q;
  assign conv_done_flag  = flag_q;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_done_effects;
    @(posedge pclk) disable iff (!presetn)
    done_ev |=> !go_q && conv_done_flag && state_q == asc_pkg::ST_WAIT;
  endproperty
  a_done_effects: assert property (p_done_effects)
    else $error("Completion did not clear go and set flag");

  property p_nref;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == asc_pkg::OFS_REFCFG)
      |=> neg_ref_select == $past(pwdata[asc_pkg::REF_NREF_BIT])
          && pos_ref_select == $past(pwdata[asc_pkg::REF_PREF_BIT]);
  endproperty
  a_nref: assert property (p_nref)
    else $error("Reference select does not follow write");

  property p_mask_all_digital;
    @(posedge pclk) disable iff (!presetn)
    (pin_config_code_q == 4'hf) |=> analog_pin_mask == 16'h0000;
  endproperty
  a_mask_all_digital: assert property (p_mask_all_digital)
    else $error("Code all ones left an analog pin");

  property p_mask_one;
    @(posedge pclk) disable iff (!presetn)
    (pin_config_code_q == 4'h1) |=> analog_pin_mask == 16'h3fff;
  endproperty
  a_mask_one: assert property (p_mask_one)
    else $error("Code one mask wrong");

  property p_right_justify;
    @(posedge pclk) disable iff (!presetn)
    (done_ev && result_justify_q) |=> result_high_byte_q[7:2] == 6'h00;
  endproperty
  a_right_justify: assert property (p_right_justify)
    else $error("Unused high bits not zero");

  property p_sleep_gate;
    @(posedge pclk) disable iff (!presetn)
    (sleep_mode && !is_rc) |-> !tick;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate)
    else $error("Divider clock ran in sleep");

  property p_rc_delay;
    @(posedge pclk) disable iff (!presetn)
    (state_q == asc_pkg::ST_IDLE && go_q && converter_on_q && is_rc)
      |=> (state_q == asc_pkg::ST_DLY) [*4];
  endproperty
  a_rc_delay: assert property (p_rc_delay)
    else $error("RC start delay not one instruction cycle");

  property p_hold_off;
    @(posedge pclk) disable iff (!presetn)
    (state_q == asc_pkg::ST_CONV) |=> !sample_connect;
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("Hold capacitor still connected in conversion");

  property p_abort_keeps;
    @(posedge pclk) disable iff (!presetn)
    (state_q == asc_pkg::ST_CONV && !go_q && converter_on_q && !wr_en)
      |=> state_q == asc_pkg::ST_WAIT && $stable(result_low_byte_q);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps)
    else $error("Abort changed result or skipped wait");

  property p_off_idle;
    @(posedge pclk) disable iff (!presetn)
    !converter_on_q |=> state_q == asc_pkg::ST_IDLE && !go_q;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("Converter off but sequencer busy");

  property p_conv_len;
    @(posedge pclk) disable iff (!presetn)
    done_ev |-> step_q == 5'd10 && $past(state_q) != asc_pkg::ST_IDLE;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("Conversion length not eleven periods");

endmodule // asc_top

// >>> testbench/asc_analog_model.sv
`timescale 1ns/1ps
module asc_analog_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [9:0] input_level,
  input  wire logic [9:0] dac_code,
  input  wire logic       sample_connect,
  output logic            cmp_high,
  output logic            rc_tick
);
  logic [9:0] held_q;
  logic [2:0] rc_cnt_q;

  // ****************************************
  // Hold capacitor and comparator
  // ****************************************
  // Tracks the pin only while connected, so a late pin change is unseen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_q <= 10'h000;
    end else if (sample_connect) begin
      held_q <= input_level;
    end
  end
  assign cmp_high = (held_q >= dac_code);

  // ****************************************
  // Internal RC source
  // ****************************************
  // Free running, one tick every 5 pclk, unrelated to requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_cnt_q <= 3'h0;
    end else begin
      rc_cnt_q <= (rc_cnt_q == 3'h4) ? 3'h0 : rc_cnt_q + 3'h1;
    end
  end
  assign rc_tick = (rc_cnt_q == 3'h4);
endmodule // asc_analog_model

// >>> testbench/adc_sequencer_control_tb_top.sv
`timescale 1ns/1ps
module adc_sequencer_control_tb_top;
  typedef struct packed {
    logic [7:0] fmt;
    logic [9:0] level;
    logic       sleep;
    int         div;
  } asc_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        rc_tick, sleep_mode, cmp_high, sample_connect, e;
  logic        neg_ref_select, pos_ref_select, conv_done_flag;
  logic [9:0]  dac_code, input_level;
  logic [15:0] analog_pin_mask;
  logic [3:0]  channel_select;
  int          failures, tests_run;
  int          acq_p [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  asc_row_t    rows [8] = '{
    '{8'h00, 10'h3ff, 1'b0, 2},  '{8'h89, 10'h001, 1'b0, 8},
    '{8'h12, 10'h2aa, 1'b0, 32}, '{8'h9b, 10'h155, 1'b1, 5},
    '{8'h24, 10'h200, 1'b0, 4},  '{8'had, 10'h1ff, 1'b0, 16},
    '{8'h36, 10'h000, 1'b0, 64}, '{8'hbf, 10'h3c3, 1'b1, 5}};

  asc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_tick(rc_tick), .sleep_mode(sleep_mode), .cmp_high(cmp_high),
    .dac_code(dac_code), .sample_connect(sample_connect),
    .neg_ref_select(neg_ref_select), .pos_ref_select(pos_ref_select),
    .analog_pin_mask(analog_pin_mask), .channel_select(channel_select),
    .conv_done_flag(conv_done_flag));
  asc_analog_model u_far (.pclk(pclk), .presetn(presetn),
    .input_level(input_level), .dac_code(dac_code),
    .sample_connect(sample_connect), .cmp_high(cmp_high),
    .rc_tick(rc_tick));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic test_done;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  // Counts carry alignment slack of the tick grid, hence a tolerance
  task automatic rng(input string n, input int g, x, tol);
    tests_run++;
    if (g < x - tol || g > x + tol) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic start(input logic [7:0] f, input logic [3:0] ch);
    apb(1'b1, asc_pkg::OFS_FMTCFG, 32'(f));
    apb(1'b1, asc_pkg::OFS_CTRL, 32'({ch, 2'b01}));
    apb(1'b1, asc_pkg::OFS_STATUS, 32'h0);
    repeat (8) @(posedge pclk);
    apb(1'b1, asc_pkg::OFS_CTRL, 32'({ch, 2'b11}));
  endtask
  task automatic wait_lvl(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 5000) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 5000) failures++;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int n;
    logic [9:0] l;
    failures = 0; tests_run = 0; presetn = 1'b0; psel = 1'b0;
    penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    sleep_mode = 1'b0; input_level = 10'h000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("mask", 32'h0000ffff, 32'(analog_pin_mask));
    for (int i = 0; i < 24; i += 4) begin
      apb(1'b0, 8'(i), 32'h0);
      if (i != 12 && i != 16) chk("rst", 32'h0, q);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("err", 32'h1, 32'(e));
    apb(1'b1, asc_pkg::OFS_FMTCFG, 32'hff);
    apb(1'b0, asc_pkg::OFS_FMTCFG, 32'h0);
    chk("fmt", 32'hbf, q);
    apb(1'b1, asc_pkg::OFS_CTRL, 32'h02);
    apb(1'b0, asc_pkg::OFS_CTRL, 32'h0);
    chk("go_off", 32'h0, q);
    for (int k = 0; k < 16; k++) begin
      apb(1'b1, asc_pkg::OFS_REFCFG, 32'({2'b11, k[0], k[1], k[3:0]}));
      apb(1'b0, asc_pkg::OFS_REFCFG, 32'h0);
      chk("ref", 32'({k[0], k[1], k[3:0]}), q);
      chk("mask", 32'(k == 0 ? 16'hffff : 16'h7fff >> k),
          32'(analog_pin_mask));
      chk("nref", 32'(k[0]), 32'(neg_ref_select));
      chk("pref", 32'(k[1]), 32'(pos_ref_select));
    end
    foreach (rows[i]) begin
      sleep_mode <= rows[i].sleep;
      input_level <= rows[i].level;
      start(rows[i].fmt, 4'(i + 7));
      chk("chan", 32'(i + 7), 32'(channel_select));
      wait_lvl(sample_connect, 1'b0, n);
      rng("acq", n, acq_p[rows[i].fmt[5:3]] * rows[i].div,
          rows[i].div + 8);
      wait_lvl(conv_done_flag, 1'b1, n);
      rng("conv", n, 11 * rows[i].div, 2);
      wait_lvl(sample_connect, 1'b1, n);
      rng("wait", n, 2 * rows[i].div, 2);
      @(posedge pclk);
      l = rows[i].level;
      apb(1'b0, asc_pkg::OFS_CTRL, 32'h0);
      chk("go", 32'({4'(i + 7), 2'b01}), q);
      apb(1'b0, asc_pkg::OFS_STATUS, 32'h0);
      chk("done", 32'h1, q);
      apb(1'b0, asc_pkg::OFS_RESHI, 32'h0);
      chk("hi", rows[i].fmt[7] ? 32'(l[9:8]) : 32'(l[9:2]), q);
      apb(1'b0, asc_pkg::OFS_RESLO, 32'h0);
      chk("lo", rows[i].fmt[7] ? 32'(l[7:0]) : 32'({l[1:0], 6'h0}),
          q);
    end
    sleep_mode <= 1'b0;
    apb(1'b1, asc_pkg::OFS_RESHI, 32'ha5);
    apb(1'b1, asc_pkg::OFS_RESLO, 32'h5a);
    start(8'h36, 4'h2);
    wait_lvl(sample_connect, 1'b0, n);
    @(posedge pclk);
    apb(1'b0, asc_pkg::OFS_CTRL, 32'h0);
    chk("busy", 32'h0b, q);
    apb(1'b1, asc_pkg::OFS_CTRL, 32'h09);
    repeat (900) @(posedge pclk);
    apb(1'b0, asc_pkg::OFS_RESHI, 32'h0);
    chk("abort_hi", 32'ha5, q);
    apb(1'b0, asc_pkg::OFS_STATUS, 32'h0);
    chk("abort_done", 32'h0, q);
    repeat (200) @(posedge pclk);
    sleep_mode <= 1'b1;
    start(8'h02, 4'h1);
    repeat (600) @(posedge pclk);
    chk("stall", 32'h0, 32'(conv_done_flag));
    sleep_mode <= 1'b0;
    wait_lvl(conv_done_flag, 1'b1, n);
    chk("resume", 32'h1, 32'(conv_done_flag));
    repeat (100) @(posedge pclk);
    start(8'h36, 4'h5);
    wait_lvl(sample_connect, 1'b0, n);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rst_mask", 32'h0000ffff, 32'(analog_pin_mask));
    chk("rst_samp", 32'h0, 32'(sample_connect));
    apb(1'b0, asc_pkg::OFS_CTRL, 32'h0);
    chk("rst_ctrl", 32'h0, q);
    test_done();
  end

  initial begin
    #1_000_000;
    failures++;
    test_done();
  end
endmodule // adc_sequencer_control_tb_top
